// *** rtl/pfie_defines.svh ***
// Constants for the program flow and interrupt entry unit.
// Assumes inclusion by bare name from rtl/ files only.
`ifndef PFIE_DEFINES_SVH
`define PFIE_DEFINES_SVH

`define PFIE_PC_W         32
`define PFIE_PC_RST       32'h0000_0100
`define PFIE_IO_LO        32'hFFFF_E000
`define PFIE_IO_LO24      24'hFF_E000
`define PFIE_FLG_MASTER_IRQ_ENABLE     7
`define PFIE_FLG_CHAINED_IRQ_ENABLE    1
`define PFIE_FLAGS_RST    8'h00
`define PFIE_PAD_BYTE     8'h00
`define PFIE_SP_RST       32'h0000_0000
`define PFIE_PAD_SKIP     32'h0000_0001
`define PFIE_BYTE_STEP    32'h0000_0001
`define PFIE_SAFE_PC      32'h0000_0000

`endif

// *** rtl/pfie_flow_unit.sv ***
// Program flow and vectored interrupt entry/return sequencer.
// Assumes a byte-wide memory port with a mem_ready handshake of any latency and an external
// interrupt controller that presents one prioritised request.
//
// Operation
// - fetch only from even addresses (sequential, EI and DI paths load instr.next_pc with bit0 unchanged)
// - never fetch from the I/O block
// - direct jump loads operand, bit0 ignored
// - relative jump adds sign-extended offset
// - enabled request diverts to service routine
// - each interrupt has 32-bit vector quad
// - enable/disable instructions set/clear master enable
// - flags write also updates master enable
// - push flags then zero pad byte
// - push PC low, copy enable, push rest
// - clear master enable before vector fetch
// - read vector MSB first into PC
// - decrement stack pointer before each store
// - plain return pops PC, skips pad, flags
// - chained return loads vector, no pops
`timescale 1ns/1ns
`default_nettype none
`include "pfie_defines.svh"
module pfie_flow_unit
    import pfie_pkg::*;
(
    input  wire logic                 clk_sys,     // Core clock
    input  wire logic                 rst_n,       // Sync reset, active low
    input  wire pfie_pkg::pfie_instr_s instr,      // Boundary instruction info
    input  wire logic                 instr_valid, // Instruction completes now
    output logic                      instr_ready, // Unit can take instruction
    input  wire logic                 flags_we,    // Direct flags write
    input  wire logic [7:0]           flags_wdata, // Flags write data
    input  wire logic [31:0]          sp_in,       // Stack pointer value
    output logic [31:0]               sp_ff,       // Stack pointer as kept here
    input  wire logic                 irq_req,     // Prioritised request
    input  wire logic [31:0]          irq_vec_addr,// Vector quad address
    output logic                      irq_ack,     // Request taken
    output pfie_pkg::pfie_mem_s       mem_ff,      // Byte memory access
    input  wire logic                 mem_ready,   // Access completes
    input  wire logic [7:0]           mem_rdata,   // Read byte
    output logic [31:0]               fetch_pc_ff, // Next fetch address
    output logic                      fetch_en_ff, // Fetch permitted
    output logic [7:0]                flags_ff,    // Flags byte
    output logic                      busy         // Sequence running
);
    typedef enum logic [6:0] {
        PFIE_IDLE  = 7'b000_0001,
        PFIE_PUSH  = 7'b000_0010,
        PFIE_VEC   = 7'b000_0100,
        PFIE_POPPC = 7'b000_1000,
        PFIE_POPFL = 7'b001_0000,
        PFIE_WAIT  = 7'b010_0000,
        PFIE_SETSP = 7'b100_0000
    } pfie_state_e;

    pfie_state_e state_ff;
    pfie_state_e nxt_state;
    logic [2:0]  cnt_ff;
    logic [2:0]  nxt_cnt;
    logic [31:0] nxt_sp;
    logic [31:0] nxt_pc;
    logic [31:0] vaddr_ff;
    logic [31:0] nxt_vaddr;
    logic [7:0]  nxt_flags;
    pfie_mem_s   nxt_mem;
    logic        nxt_fetch_en;
    logic [31:0] jmp_target;
    logic        master_irq_enable;
    logic        in_io;

    assign master_irq_enable = flags_ff[`PFIE_FLG_MASTER_IRQ_ENABLE];

    pfie_target_calc u_tgt (
        .pc       (instr.next_pc),
        .direct   (instr.op == PFIE_OP_JDIR),
        .rel_size (instr.rel_size),
        .operand  (instr.operand),
        .target   (jmp_target)
    );

    assign instr_ready = (state_ff == PFIE_IDLE);
    assign busy        = (state_ff != PFIE_IDLE);
    assign irq_ack     = (state_ff == PFIE_IDLE) && instr_valid && irq_req && master_irq_enable
                         && (instr.op != PFIE_OP_INTERRUPT_RETURN_INSTR);

    // Byte pushed at push step n: flags, pad, PC low to high
    function automatic logic [7:0] push_byte(input logic [2:0] n, input logic [7:0] f,
                                             input logic [31:0] p);
        logic [7:0] b;
        b = 8'h00;
        case (n)
            3'd0:    b = f;
            3'd1:    b = `PFIE_PAD_BYTE;
            3'd2:    b = p[7:0];
            3'd3:    b = p[15:8];
            3'd4:    b = p[23:16];
            3'd5:    b = p[31:24];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    always_comb begin
        nxt_state    = state_ff;
        nxt_cnt      = cnt_ff;
        nxt_sp       = sp_ff;
        nxt_pc       = fetch_pc_ff;
        nxt_vaddr    = vaddr_ff;
        nxt_flags    = flags_ff;
        nxt_mem      = mem_ff;
        nxt_fetch_en = fetch_en_ff;
        case (state_ff)
            PFIE_IDLE: begin
                nxt_mem.req = 1'b0;
                if (flags_we) begin
                    nxt_flags = flags_wdata;
                end
                if (instr_valid) begin
                    nxt_sp       = sp_in;
                    nxt_pc       = instr.next_pc;
                    nxt_fetch_en = 1'b1;
                    case (instr.op)
                        PFIE_OP_JDIR, PFIE_OP_JREL: nxt_pc = jmp_target;
                        PFIE_OP_EI: nxt_flags[`PFIE_FLG_MASTER_IRQ_ENABLE] = 1'b1;
                        PFIE_OP_DI: nxt_flags[`PFIE_FLG_MASTER_IRQ_ENABLE] = 1'b0;
                        default: nxt_pc = instr.next_pc;
                    endcase
                    if (instr.op == PFIE_OP_INTERRUPT_RETURN_INSTR) begin
                        nxt_fetch_en = 1'b0;
                        if (flags_ff[`PFIE_FLG_CHAINED_IRQ_ENABLE] && irq_req) begin
                            nxt_flags[`PFIE_FLG_MASTER_IRQ_ENABLE] = 1'b0;
                            nxt_vaddr = irq_vec_addr;
                            nxt_cnt   = 3'd0;
                            nxt_state = PFIE_VEC;
                        end else begin
                            nxt_cnt   = 3'd0;
                            nxt_state = PFIE_POPPC;
                        end
                    end else if (irq_req && master_irq_enable) begin
                        nxt_fetch_en = 1'b0;
                        nxt_vaddr    = irq_vec_addr;
                        nxt_cnt      = 3'd0;
                        nxt_state    = PFIE_SETSP;
                    end
                end
            end
            PFIE_SETSP: begin
                // Predecrement, then store the byte at the new pointer
                nxt_sp        = sp_ff - `PFIE_BYTE_STEP;
                nxt_mem.req   = 1'b1;
                nxt_mem.we    = 1'b1;
                nxt_mem.addr  = sp_ff - `PFIE_BYTE_STEP;
                nxt_mem.wdata = push_byte(cnt_ff, flags_ff, fetch_pc_ff);
                nxt_state     = PFIE_PUSH;
            end
            PFIE_PUSH: begin
                if (mem_ready) begin
                    nxt_mem.req = 1'b0;
                    if (cnt_ff == 3'd2) begin
                        nxt_flags[`PFIE_FLG_CHAINED_IRQ_ENABLE] = master_irq_enable;
                    end
                    if (cnt_ff == 3'd5) begin
                        nxt_flags[`PFIE_FLG_MASTER_IRQ_ENABLE] = 1'b0;
                        nxt_cnt   = 3'd0;
                        nxt_state = PFIE_VEC;
                    end else begin
                        nxt_cnt   = cnt_ff + 3'd1;
                        nxt_state = PFIE_SETSP;
                    end
                end
            end
            PFIE_VEC: begin
                nxt_mem.req   = 1'b1;
                nxt_mem.we    = 1'b0;
                nxt_mem.addr  = vaddr_ff + {29'h0000_0000, cnt_ff};
                nxt_mem.wdata = 8'h00;
                if (mem_ff.req && !mem_ff.we && mem_ready) begin
                    // Quad is big-endian: byte 0 is bits 31:24
                    case (cnt_ff)
                        3'd0:    nxt_pc[31:24] = mem_rdata;
                        3'd1:    nxt_pc[23:16] = mem_rdata;
                        3'd2:    nxt_pc[15:8]  = mem_rdata;
                        default: nxt_pc[7:0]   = mem_rdata;
                    endcase
                    nxt_mem.req = 1'b0;
                    if (cnt_ff == 3'd3) begin
                        nxt_state = PFIE_WAIT;
                    end else begin
                        nxt_cnt = cnt_ff + 3'd1;
                    end
                end
            end
            PFIE_POPPC: begin
                nxt_mem.req   = 1'b1;
                nxt_mem.we    = 1'b0;
                nxt_mem.addr  = sp_ff;
                nxt_mem.wdata = 8'h00;
                if (mem_ff.req && !mem_ff.we && mem_ready) begin
                    case (cnt_ff)
                        3'd0:    nxt_pc[31:24] = mem_rdata;
                        3'd1:    nxt_pc[23:16] = mem_rdata;
                        3'd2:    nxt_pc[15:8]  = mem_rdata;
                        default: nxt_pc[7:0]   = mem_rdata;
                    endcase
                    nxt_mem.req = 1'b0;
                    if (cnt_ff == 3'd3) begin
                        nxt_sp    = sp_ff + `PFIE_BYTE_STEP + `PFIE_PAD_SKIP;
                        nxt_state = PFIE_POPFL;
                    end else begin
                        nxt_sp  = sp_ff + `PFIE_BYTE_STEP;
                        nxt_cnt = cnt_ff + 3'd1;
                    end
                end
            end
            PFIE_POPFL: begin
                nxt_mem.req   = 1'b1;
                nxt_mem.we    = 1'b0;
                nxt_mem.addr  = sp_ff;
                nxt_mem.wdata = 8'h00;
                if (mem_ff.req && !mem_ff.we && mem_ready) begin
                    nxt_flags   = mem_rdata;
                    nxt_sp      = sp_ff + `PFIE_BYTE_STEP;
                    nxt_mem.req = 1'b0;
                    nxt_state   = PFIE_WAIT;
                end
            end
            PFIE_WAIT: begin
                nxt_pc[0]    = 1'b0;
                nxt_fetch_en = 1'b1;
                nxt_state    = PFIE_IDLE;
            end
            default: begin
                nxt_state = PFIE_IDLE;
            end
        endcase
        // Fetch block for the I/O region, also with upper byte ignored
        in_io = (nxt_pc >= `PFIE_IO_LO) || (nxt_pc[23:0] >= `PFIE_IO_LO24);
        if (nxt_fetch_en && in_io) begin
            nxt_fetch_en = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff    <= PFIE_IDLE;
            cnt_ff      <= 3'd0;
            sp_ff       <= `PFIE_SP_RST;
            fetch_pc_ff <= `PFIE_PC_RST;
            vaddr_ff    <= 32'h0000_0000;
            flags_ff    <= `PFIE_FLAGS_RST;
            mem_ff      <= '0;
            fetch_en_ff <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            cnt_ff      <= nxt_cnt;
            sp_ff       <= nxt_sp;
            fetch_pc_ff <= nxt_pc;
            vaddr_ff    <= nxt_vaddr;
            flags_ff    <= nxt_flags;
            mem_ff      <= nxt_mem;
            fetch_en_ff <= nxt_fetch_en;
        end
    end
endmodule
`default_nettype wire

// *** rtl/pfie_pkg.sv ***
// Types shared by the program flow and interrupt entry unit.
// Assumes nothing beyond a SystemVerilog compiler.
package pfie_pkg;
    typedef enum logic [1:0] {
        PFIE_REL8  = 2'h0,
        PFIE_REL12 = 2'h1,
        PFIE_REL16 = 2'h2,
        PFIE_REL24 = 2'h3
    } pfie_rel_e;

    typedef enum logic [2:0] {
        PFIE_OP_NONE = 3'h0,
        PFIE_OP_JDIR = 3'h1,
        PFIE_OP_JREL = 3'h2,
        PFIE_OP_EI   = 3'h3,
        PFIE_OP_DI   = 3'h4,
        PFIE_OP_INTERRUPT_RETURN_INSTR = 3'h5,
        PFIE_OP_SEQ  = 3'h6
    } pfie_op_e;

    // Instruction boundary request from the decoder
    typedef struct packed {
        pfie_op_e    op;
        pfie_rel_e   rel_size;
        logic [31:0] operand;
        logic [31:0] next_pc;
    } pfie_instr_s;

    // Byte memory access towards stack and vector space
    typedef struct packed {
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } pfie_mem_s;
endpackage

// *** rtl/pfie_target_calc.sv ***
// Jump target formation: direct and sign-extended relative forms.
// Assumes combinational use inside the flow unit.
`timescale 1ns/1ns
`default_nettype none
`include "pfie_defines.svh"
module pfie_target_calc
    import pfie_pkg::*;
(
    input  wire logic [31:0]       pc,        // Base program counter
    input  wire logic              direct,    // Direct address form
    input  wire pfie_pkg::pfie_rel_e rel_size, // Relative field width
    input  wire logic [31:0]       operand,   // Operand bytes
    output logic [31:0]            target     // Even target address
);
    logic [31:0] ofs;

    always_comb begin
        case (rel_size)
            PFIE_REL8:  ofs = {{24{operand[7]}}, operand[7:0]};
            PFIE_REL12: ofs = {{20{operand[11]}}, operand[11:0]};
            PFIE_REL16: ofs = {{16{operand[15]}}, operand[15:0]};
            PFIE_REL24: ofs = {{8{operand[23]}}, operand[23:0]};
            default:    ofs = 32'h0000_0000;
        endcase
        if (direct) begin
            target = {operand[31:1], 1'b0};
        end else begin
            target = {ofs[31:1] + pc[31:1], 1'b0};
        end
    end
endmodule
`default_nettype wire

// *** test/pfie_flow_unit_bench.sv ***
// Self-checking bench for the flow unit.
// Assumes the memory model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module pfie_flow_unit_bench;
    import pfie_pkg::*;
    logic        clk_sys = 0, rst_n = 0, instr_valid = 0, flags_we = 0, irq_req = 0, slow = 0;
    pfie_instr_s instr = '0;
    logic [7:0]  flags_wdata = 0, flags_ff, mem_rdata;
    logic [31:0] sp_in = 0, irq_vec_addr = 0, sp_ff, fetch_pc_ff;
    logic        instr_ready, irq_ack, mem_ready, fetch_en_ff, busy, jp = 0, pb = 0;
    pfie_mem_s   mem_ff;
    int          n_mismatch = 0, checked = 0;
    logic [39:0] q_wr [$];
    logic [71:0] q_st [$];
    always #5 clk_sys = ~clk_sys;
    pfie_flow_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .flags_we(flags_we),
        .flags_wdata(flags_wdata), .sp_in(sp_in), .sp_ff(sp_ff), .irq_req(irq_req),
        .irq_vec_addr(irq_vec_addr), .irq_ack(irq_ack), .mem_ff(mem_ff), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .fetch_pc_ff(fetch_pc_ff), .fetch_en_ff(fetch_en_ff),
        .flags_ff(flags_ff), .busy(busy));
    pfie_mem_model pm (.clk_sys(clk_sys), .mem(mem_ff), .slow(slow), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata));
    task automatic tally(input logic [71:0] g, e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk_mem(input logic [39:0] g, e);
        tally({32'h0, g}, {32'h0, e});
    endtask
    task automatic chk_st(input logic [71:0] g, e);
        tally(g, e);
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic issue(input pfie_op_e o, input pfie_rel_e r, input logic [31:0] d, np);
        instr = {o, r, d, np};
        instr_valid = 1;
        @(posedge clk_sys);
        #1;
        instr_valid = 0;
        @(posedge clk_sys) #1;
    endtask
    task automatic idle;
        for (int i = 0; i < 300 && (busy !== 1'b0 || instr_ready !== 1'b1); i++) @(posedge clk_sys) #1;
        if (busy !== 1'b0) n_mismatch++;
        @(posedge clk_sys) #1;
    endtask
    function automatic logic [31:0] sx(input pfie_rel_e r, input logic [31:0] d);
        case (r)
            PFIE_REL8:  return {{24{d[7]}}, d[7:0]};
            PFIE_REL12: return {{20{d[11]}}, d[11:0]};
            PFIE_REL16: return {{16{d[15]}}, d[15:0]};
            default:    return {{8{d[23]}}, d[23:0]};
        endcase
    endfunction
    // Fetch allowed only outside the I/O block, upper byte ignored or not
    function automatic logic ok_en(input logic [31:0] t);
        return !(t >= 32'hffff_e000 || t[23:0] >= 24'hff_e000);
    endfunction
    // Watcher compares each result against the oldest note
    always @(negedge clk_sys) begin
        if (rst_n) begin
            if (mem_ff.req && mem_ff.we && mem_ready) begin
                chk_mem({mem_ff.addr, mem_ff.wdata}, q_wr.pop_front());
            end
            if (jp) chk_st({39'h0, fetch_en_ff, fetch_pc_ff}, q_st.pop_front());
            if (pb && !busy) chk_st({fetch_pc_ff, sp_ff, flags_ff}, q_st.pop_front());
            jp = instr_valid && instr_ready && !irq_ack
                && (instr.op == PFIE_OP_JDIR || instr.op == PFIE_OP_JREL);
            pb = busy;
        end
    end
    initial begin
        #300000;
        n_mismatch++;
        final_report;
    end
    initial begin
        logic [31:0] u, s, p, a, b, d, msk;
        int w;
        void'($urandom(32'ha7b0));
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1;
        for (int k = 0; k < 2; k++) begin
            slow = k[0];
            issue(PFIE_OP_EI, PFIE_REL8, 0, 32'h200);
            issue(PFIE_OP_DI, PFIE_REL8, 0, 32'h202);
            flags_we = 1;
            flags_wdata = 8'h80;
            @(posedge clk_sys) #1;
            flags_we = 0;
            u = $urandom;
            s = {16'h0001, u[15:1], 1'b0};
            p = {8'h00, u[31:17], 9'h100};
            a = $urandom & 32'h00ff_00fe;
            b = $urandom & 32'h00ff_00fe;
            for (int i = 0; i < 4; i++) begin
                pm.m[32'h14 + i] = a[31 - 8 * i -: 8];
                pm.m[32'h18 + i] = b[31 - 8 * i -: 8];
            end
            q_wr.push_back({s - 32'h1, 8'h80});
            q_wr.push_back({s - 32'h2, 8'h00});
            for (int i = 0; i < 4; i++) q_wr.push_back({s - 32'h3 - i, p[8 * i +: 8]});
            q_st.push_back({a, s - 32'h6, 8'h02});
            sp_in = s;
            irq_vec_addr = 32'h14;
            irq_req = 1;
            issue(PFIE_OP_SEQ, PFIE_REL8, 0, p);
            irq_req = 0;
            idle;
            q_st.push_back({b, s - 32'h6, 8'h02});
            irq_vec_addr = 32'h18;
            sp_in = s - 32'h6;
            irq_req = 1;
            issue(PFIE_OP_INTERRUPT_RETURN_INSTR, PFIE_REL8, 0, a);
            irq_req = 0;
            idle;
            q_st.push_back({p, s, 8'h80});
            issue(PFIE_OP_INTERRUPT_RETURN_INSTR, PFIE_REL8, 0, b);
            idle;
            issue(PFIE_OP_DI, PFIE_REL8, 0, p);
        end
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 3; k++) begin
                w = (r == 3) ? 24 : 8 + 4 * r;
                msk = (32'h1 << w) - 32'h1;
                u = $urandom;
                d = (k == 0) ? (msk >> 1) - 32'h1 : (k == 1) ? (msk >> 1) + 32'h1 : u & msk;
                d = (u & ~msk) | (d & msk & 32'hffff_fffe);
                p = {8'h01, u[23:1], 1'b0};
                a = p + sx(pfie_rel_e'(r), d);
                q_st.push_back({39'h0, ok_en(a), a});
                issue(PFIE_OP_JREL, pfie_rel_e'(r), d, p);
            end
        end
        d = $urandom | 32'h1;
        a = d & 32'hffff_fffe;
        q_st.push_back({39'h0, ok_en(a), a});
        issue(PFIE_OP_JDIR, PFIE_REL8, d, 32'h300);
        q_st.push_back({39'h0, 1'b0, 32'hffff_e000});
        issue(PFIE_OP_JDIR, PFIE_REL8, 32'hffff_e001, 32'h302);
        q_st.push_back({39'h0, 1'b0, 32'h00ff_e002});
        issue(PFIE_OP_JDIR, PFIE_REL8, 32'h00ff_e002, 32'h304);
        repeat (4) @(posedge clk_sys);
        final_report;
    end
endmodule
`default_nettype wire

// *** test/pfie_flow_unit_chk.sv ***
// Port-level checks of the flow unit.
// Assumes binding to pfie_flow_unit.
`timescale 1ns/1ns
`default_nettype none
module pfie_flow_unit_chk
    import pfie_pkg::*;
(
    input wire logic                 clk_sys,     // Clock
    input wire logic                 rst_n,       // Reset
    input wire pfie_pkg::pfie_instr_s instr,      // Instruction
    input wire logic                 instr_valid, // Valid
    input wire logic                 instr_ready, // Ready
    input wire logic                 flags_we,    // Flags write
    input wire logic [7:0]           flags_wdata, // Flags data
    input wire logic [31:0]          sp_in,       // SP in
    input wire logic [31:0]          sp_ff,       // SP kept
    input wire logic                 irq_req,     // Request
    input wire logic [31:0]          irq_vec_addr,// Vector address
    input wire logic                 irq_ack,     // Taken
    input wire pfie_pkg::pfie_mem_s  mem_ff,      // Memory access
    input wire logic                 mem_ready,   // Access done
    input wire logic [7:0]           mem_rdata,   // Read byte
    input wire logic [31:0]          fetch_pc_ff, // Fetch address
    input wire logic                 fetch_en_ff, // Fetch enable
    input wire logic [7:0]           flags_ff,    // Flags
    input wire logic                 busy         // Busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic acc;
    logic in_entry_ff;
    logic nxt_in_entry;
    assign acc = instr_valid && instr_ready;
    always_comb nxt_in_entry = rst_n && (irq_ack || (busy && in_entry_ff));
    always_ff @(posedge clk_sys) in_entry_ff <= nxt_in_entry;

    chk_fetch_even: assert property (fetch_en_ff |-> !fetch_pc_ff[0])
        else $error("odd fetch address");
    chk_io_block: assert property (fetch_pc_ff[23:0] >= 24'hff_e000 |-> !fetch_en_ff)
        else $error("fetch from io block");
    chk_direct_load: assert property (acc && instr.op == PFIE_OP_JDIR && !irq_ack
        |=> fetch_pc_ff == ($past(instr.operand) & 32'hffff_fffe)) else $error("direct jump");
    chk_ei_sets: assert property (acc && instr.op == PFIE_OP_EI |=> flags_ff[7])
        else $error("enable instr");
    chk_di_clears: assert property (acc && instr.op == PFIE_OP_DI && !irq_ack
        |=> !flags_ff[7]) else $error("disable instr");
    chk_flags_write: assert property (flags_we && instr_ready && !instr_valid
        |=> flags_ff[7] == $past(flags_wdata[7])) else $error("flags write");
    chk_ack_cause: assert property (irq_ack |-> acc && irq_req)
        else $error("ack off boundary");
    chk_irq_taken: assert property (acc && irq_req && flags_ff[7]
        && instr.op != PFIE_OP_INTERRUPT_RETURN_INSTR |-> irq_ack) else $error("request not taken");
    chk_flags_push: assert property (irq_ack |=> ##1 mem_ff.req && mem_ff.we
        && mem_ff.addr == $past(sp_in, 2) - 32'h0000_0001 && mem_ff.wdata == $past(flags_ff, 2))
        else $error("flags push");
    chk_vec_masked: assert property (in_entry_ff && mem_ff.req && !mem_ff.we |-> !flags_ff[7])
        else $error("vector read enabled");
    chk_busy_refuse: assert property (busy |-> !instr_ready)
        else $error("ready while busy");
    cov_entry: cover property (irq_ack);
    cov_vec_read: cover property (mem_ff.req && !mem_ff.we && mem_ready);
    cov_interrupt_return_instr: cover property (acc && instr.op == PFIE_OP_INTERRUPT_RETURN_INSTR);
endmodule
bind pfie_flow_unit pfie_flow_unit_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .flags_we(flags_we),
    .flags_wdata(flags_wdata), .sp_in(sp_in), .sp_ff(sp_ff), .irq_req(irq_req),
    .irq_vec_addr(irq_vec_addr), .irq_ack(irq_ack), .mem_ff(mem_ff), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .fetch_pc_ff(fetch_pc_ff), .fetch_en_ff(fetch_en_ff),
    .flags_ff(flags_ff), .busy(busy));
`default_nettype wire

// *** test/pfie_mem_model.sv ***
// Byte memory behind the flow unit's stack and vector port.
// Assumes one access at a time, held until mem_ready is seen.
`timescale 1ns/1ns
`default_nettype none
module pfie_mem_model
    import pfie_pkg::*;
(
    input  wire logic                clk_sys,   // Clock
    input  wire pfie_pkg::pfie_mem_s mem,       // Access request
    input  wire logic                slow,      // Add wait cycles
    output logic                     mem_ready, // Access done
    output logic [7:0]               mem_rdata  // Read byte
);
    logic [7:0]  m [logic [31:0]];
    logic [1:0]  cnt = 2'h0;
    logic        done = 1'b0;
    logic [31:0] last_a = 32'h0;
    initial mem_ready = 1'b0;
    initial mem_rdata = 8'h00;
    // Read data toggles outside the ready cycle
    always @(posedge clk_sys) begin
        mem_ready <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (!mem.req || mem.addr != last_a) done <= 1'b0;
        if (mem.req && !(done && mem.addr == last_a) && !mem_ready) begin
            if (slow && cnt != 2'h3) cnt <= cnt + 2'h1;
            else begin
                cnt <= 2'h0;
                mem_ready <= 1'b1;
                done <= 1'b1;
                last_a <= mem.addr;
                if (mem.we) m[mem.addr] = mem.wdata;
                else mem_rdata <= m.exists(mem.addr) ? m[mem.addr] : 8'h5a;
            end
        end
    end
endmodule
`default_nettype wire
